// ==== bench/sap_master_model.sv ====
// serial clock master model for the position link
`timescale 1ns/1ps
`default_nettype none
module sap_master_model (
  // serial link
  output var  logic ssi_clk_pin,
  input  wire logic ssi_data
);
  localparam real HALF = 62.5;
  initial ssi_clk_pin = 1'b1;
  // min(nr, n+1) rises, plus a closing one when nr <= n; a bit is taken on the fall after each of the first n of them
  task automatic read(input int nr, input int n, output logic [28:0] w);
    w = 29'h0;
    #(HALF) ssi_clk_pin = 1'b0;
    for (int k = 1; k <= nr; k++) begin
      #(HALF) ssi_clk_pin = 1'b1;
      if (k <= n) begin
        #(HALF) ssi_clk_pin = 1'b0;
        w = {w[27:0], ssi_data};
      end
    end
    #(HALF) ssi_clk_pin = 1'b1;
  endtask : read
endmodule : sap_master_model
`default_nettype wire

// ==== bench/test_sap_ssi_output.sv ====
// self-checking bench for the serial position output
`timescale 1ns/1ps
`default_nettype none
module test_sap_ssi_output;
  import sap_pkg::*;
  localparam int REC = 64;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  sap_pos_t    pos = '0;
  sap_cfg_t    cfg = '0;
  logic        ssi_clk_pin;
  logic        ssi_data;
  logic [28:0] w;
  int          n_fail = 0;
  int          num_checks = 0;
  always #2.5 clk = ~clk;
  sap_ssi_output #(.RECOVERY_CYCLES(REC)) i_dut (.clk(clk), .reset(reset), .pos(pos),
    .cfg(cfg), .ssi_clk_pin(ssi_clk_pin), .ssi_data(ssi_data));
  sap_master_model i_m (.ssi_clk_pin(ssi_clk_pin), .ssi_data(ssi_data));
  task automatic check(input logic [28:0] s, input logic [28:0] e);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : check
  task automatic setup(input sap_cfg_t c, input sap_pos_t p);
    @(posedge clk);
    #1;
    cfg = c;
    pos = p;
  endtask : setup
  task automatic rd(input int n, input logic [28:0] e);
    i_m.read(n + 1, n, w);
    check(w, e);
    check({28'h0, ssi_data}, 29'h0);
  endtask : rd
  task automatic idle;
    int c = 0;
    while (ssi_data !== 1'b1 && c < REC + 40) begin
      @(posedge clk);
      c++;
    end
    check({28'h0, ssi_data}, 29'h1);
    check(29'(c > REC - 16), 29'h1);
  endtask : idle
  task automatic t_rep;
    setup('{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 17'h0}, 29'h0f0f0f0f);
    rd(29, 29'h0f0f0f0f);
    setup(cfg, 29'h10305070);
    rd(29, 29'h0f0f0f0f);
    idle();
    rd(29, 29'h10305070);
    idle();
    $display("restart reads done");
  endtask : t_rep
  task automatic t_gray;
    logic [16:0] v;
    logic [28:0] g[3];
    for (int r = 0; r < 3; r++) begin
      v = 17'h1b6d5 + 17'(r == 2);
      setup('{1'b1, 1'b1, r == 1, 1'b0, 1'b0, 17'h0}, {12'h5a5, v});
      rd(17, {12'h0, v ^ (v >> 1) ^ {r == 1, 16'h0}});
      g[r] = w;
      idle();
    end
    check(29'($countones(g[0] ^ g[2])), 29'h1);
    setup('{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 17'h002d0}, 29'h00123);
    v = 17'h00123 + 17'((18'h20000 - 18'h002d0) >> 1);
    rd(17, {12'h0, v ^ (v >> 1)});
    idle();
    setup(cfg, 29'h002d5);
    v = 17'h00005 + 17'((18'h20000 - 18'h002d0) >> 1);
    rd(17, {12'h0, v ^ (v >> 1)});
    idle();
    $display("gray reads done");
  endtask : t_gray
  task automatic t_abort;
    setup('{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 17'h0}, 29'h0e000000);
    i_m.read(5, 29, w);
    check(w, 29'h0000000e);
    check({28'h0, ssi_data}, 29'h0);
    idle();
    $display("abort read done");
  endtask : t_abort
  task automatic t_old;
    setup('{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 17'h0}, 29'h01234567);
    i_m.read(30, 29, w);
    idle();
    repeat (4) @(posedge clk);
    setup(cfg, 29'h07654321);
    rd(29, 29'h01234567);
    idle();
    rd(29, 29'h07654321);
    idle();
    $display("older variant reads done");
  endtask : t_old
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (12) @(posedge clk);
    #1;
    reset = 1'b0;
    check({28'h0, ssi_data}, 29'h1);
    t_rep();
    t_gray();
    t_abort();
    t_old();
    complete_run();
  end
  initial begin
    #200000;
    n_fail++;
    complete_run();
  end
endmodule : test_sap_ssi_output
`default_nettype wire

// ==== rtl/sap_pkg.sv ====
// shared constants and types for the serial absolute position output
package sap_pkg;

  localparam int ANGLE_BITS = 17;
  localparam int TURN_BITS  = 12;
  localparam int WORD_BITS  = ANGLE_BITS + TURN_BITS;
  localparam int CNT_BITS   = 5;
  localparam int TMR_BITS   = 14;

  localparam logic [CNT_BITS-1:0]   MULTI_BITS  = 5'h1d;
  localparam logic [CNT_BITS-1:0]   SINGLE_BITS = 5'h11;
  localparam logic [ANGLE_BITS:0]   ANGLE_SPAN  = 18'h20000;
  localparam logic [TURN_BITS-1:0]  PAD_ZERO    = 12'h000;

  localparam int CLK_PERIOD_NS = 5;
  localparam int IDLE_RECOVERY_INTERVAL_NS = 40000;
  localparam int IDLE_RECOVERY_CYCLES = IDLE_RECOVERY_INTERVAL_NS / CLK_PERIOD_NS;

  localparam logic DATA_IDLE  = 1'b1;
  localparam logic DATA_RECOV = 1'b0;

  typedef struct packed {
    logic [TURN_BITS-1:0]  turns;
    logic [ANGLE_BITS-1:0] angle;
  } sap_pos_t;

  typedef struct packed {
    logic                  variant_new;
    logic                  gray_en;
    logic                  reverse;
    logic                  multiturn;
    logic                  capped;
    logic [ANGLE_BITS-1:0] divisions;
  } sap_cfg_t;

  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_RECOVER} sap_state_t;

  function automatic logic [WORD_BITS-1:0] sap_gray(input logic [WORD_BITS-1:0] b);
    sap_gray = b ^ (b >> 1);
  endfunction : sap_gray

endpackage : sap_pkg

// ==== rtl/sap_ssi_output.sv ====
// serial absolute position output, clock-and-data link slave
`timescale 1ns/1ps
`default_nettype none
module sap_ssi_output #(
  parameter int RECOVERY_CYCLES = sap_pkg::IDLE_RECOVERY_CYCLES
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // position source and setup
  input  wire sap_pkg::sap_pos_t pos,
  input  wire sap_pkg::sap_cfg_t cfg,
  // serial link
  input  wire logic             ssi_clk_pin,
  output var  logic             ssi_data
);
  import sap_pkg::*;

  localparam logic [TMR_BITS-1:0] TMR_LAST = TMR_BITS'(RECOVERY_CYCLES - 1);

  // link clock sampling
  logic sclk_s1;
  logic sclk_s2;
  logic sclk_prev;
  always_ff @(posedge clk) begin
    if (reset) begin
      sclk_s1   <= 1'b1;
      sclk_s2   <= 1'b1;
      sclk_prev <= 1'b1;
    end else begin
      sclk_s1   <= ssi_clk_pin;
      sclk_s2   <= sclk_s1;
      sclk_prev <= sclk_s2;
    end
  end
  wire logic clk_fall = sclk_prev & ~sclk_s2;
  wire logic clk_rise = ~sclk_prev & sclk_s2;

  // position word forming
  wire logic [ANGLE_BITS:0]   excess   = ANGLE_SPAN - {1'b0, cfg.divisions};
  wire logic [ANGLE_BITS-1:0] offset   = cfg.capped ? excess[ANGLE_BITS:1] : '0;
  wire logic                  over     = cfg.capped && (pos.angle >= cfg.divisions);
  wire logic [ANGLE_BITS-1:0] ang_wrap = over ? pos.angle - cfg.divisions : pos.angle;
  wire logic [ANGLE_BITS-1:0] ang_code = ang_wrap + offset;
  wire logic [WORD_BITS-1:0]  bin_word = cfg.multiturn ? {pos.turns, ang_code}
                                                       : {ang_code, PAD_ZERO};
  wire logic [WORD_BITS-1:0]  gry_word = sap_gray(bin_word);
  wire logic [WORD_BITS-1:0]  rev_mask = {cfg.reverse, {(WORD_BITS-1){1'b0}}};
  wire logic [WORD_BITS-1:0]  live_word = cfg.gray_en ? (gry_word ^ rev_mask) : bin_word;
  wire logic [CNT_BITS-1:0]   nbits    = cfg.multiturn ? MULTI_BITS : SINGLE_BITS;

  // transfer state
  sap_state_t            state;
  logic [WORD_BITS-1:0]  shift_word;
  logic [WORD_BITS-1:0]  tx_word;
  logic [WORD_BITS-1:0]  sample_word;
  logic                  need_sample;
  logic [CNT_BITS-1:0]   bit_cnt;
  logic [TMR_BITS-1:0]   tmr;

  wire logic tmr_done   = (tmr == TMR_LAST);
  wire logic word_done  = (bit_cnt == nbits);
  wire logic start_read = (state == ST_IDLE) && clk_fall;
  wire logic rerun      = (state == ST_RECOVER) && clk_fall && cfg.variant_new;
  // a read right after return to idle must not resend the last sample
  wire logic use_live   = cfg.variant_new || need_sample;
  wire logic [WORD_BITS-1:0] fresh_word = use_live ? live_word : sample_word;

  always_ff @(posedge clk) begin
    if (reset) begin
      state       <= ST_IDLE;
      shift_word  <= '0;
      tx_word     <= '0;
      sample_word <= '0;
      need_sample <= 1'b1;
      bit_cnt     <= '0;
      tmr         <= '0;
      ssi_data    <= DATA_IDLE;
    end else begin
      if (need_sample) begin
        sample_word <= live_word;
        need_sample <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          ssi_data <= DATA_IDLE;
          if (clk_fall) begin
            shift_word <= fresh_word;
            tx_word    <= fresh_word;
            bit_cnt    <= '0;
            tmr        <= '0;
            state      <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (clk_rise && !word_done) begin
            ssi_data   <= shift_word[WORD_BITS-1];
            shift_word <= shift_word << 1;
            bit_cnt    <= bit_cnt + 1'b1;
            tmr        <= '0;
          end else if (clk_rise) begin
            ssi_data <= DATA_RECOV;
            tmr      <= '0;
            state    <= ST_RECOVER;
          end else if (clk_fall) begin
            tmr <= '0;
          end else if (tmr_done) begin
            ssi_data    <= DATA_IDLE;
            need_sample <= 1'b1;
            state       <= ST_IDLE;
          end else begin
            tmr <= tmr + 1'b1;
          end
        end
        ST_RECOVER: begin
          if (rerun) begin
            shift_word <= tx_word;
            bit_cnt    <= '0;
            tmr        <= '0;
            state      <= ST_SHIFT;
          end else if (tmr_done) begin
            ssi_data    <= DATA_IDLE;
            need_sample <= 1'b1;
            state       <= ST_IDLE;
          end else begin
            tmr <= tmr + 1'b1;
          end
        end
        default: begin
          ssi_data <= DATA_IDLE;
          state    <= ST_IDLE;
        end
      endcase
    end
  end

  // recovery length watch, independent of the transfer timer
  logic [TMR_BITS-1:0] rec_len;
  always_ff @(posedge clk) begin
    if (reset || state != ST_RECOVER) begin
      rec_len <= '0;
    end else begin
      rec_len <= rec_len + 1'b1;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_last_edge;
    (state == ST_SHIFT) && clk_rise && word_done;
  endsequence

  sequence s_recover_end;
    (state == ST_RECOVER) && !clk_fall && tmr_done;
  endsequence

  idle_data_high_a: assert property ((state == ST_IDLE) |-> ssi_data)
    else $error("data not high while idle");

  latch_on_fall_a: assert property (start_read |=> shift_word == $past(fresh_word))
    else $error("word not latched at first falling edge");

  new_is_live_a: assert property (start_read && cfg.variant_new
      |=> tx_word == $past(live_word))
    else $error("newer variant did not take live position");

  msb_first_a: assert property ((state == ST_SHIFT) && clk_rise && !word_done
      |=> ssi_data == $past(shift_word[WORD_BITS-1]) && bit_cnt == $past(bit_cnt) + 1'b1)
    else $error("bit out of order");

  recovery_low_a: assert property (s_last_edge |=> !ssi_data && state == ST_RECOVER
      ##1 (!ssi_data) [*3])
    else $error("data not low after last edge");

  recovery_ends_a: assert property (s_recover_end |=> ssi_data && state == ST_IDLE)
    else $error("data not released after recovery");

  recovery_bound_a: assert property ((state == ST_RECOVER) |-> rec_len <= TMR_LAST)
    else $error("recovery longer than limit");

  repeat_word_a: assert property (rerun |=> shift_word == $past(tx_word)
      && tx_word == $past(tx_word))
    else $error("early restart did not repeat word");

  old_sample_a: assert property ((s_recover_end and !cfg.variant_new) ##2 1'b1
      |-> sample_word == $past(live_word))
    else $error("older variant did not send refreshed sample");

  abort_release_a: assert property ((state == ST_SHIFT) && !clk_rise && !clk_fall
      && tmr_done |=> ssi_data && state == ST_IDLE)
    else $error("aborted read not released");

  gray_step_a: assert property (cfg.gray_en
      |-> $onehot(sap_gray(bin_word) ^ sap_gray(bin_word + 1'b1)))
    else $error("gray neighbours differ in more than one bit");

  reverse_msb_a: assert property (cfg.gray_en && cfg.reverse
      |-> live_word[WORD_BITS-1] != bin_word[WORD_BITS-1])
    else $error("reverse did not invert top bit");

endmodule : sap_ssi_output
`default_nettype wire
